/* design/cbs_pkg.sv */
package cbs_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 3;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_BRANCH_NEGATIVE             = 8'h01;
  localparam logic [7:0] OP_BRANCH_ZERO                 = 8'h02;
  localparam logic [7:0] OP_BRANCH_CARRY_SET            = 8'h03;
  localparam logic [7:0] OP_BRANCH_POSITIVE             = 8'h04;
  localparam logic [7:0] OP_BRANCH_POSITIVE_OR_ZERO     = 8'h05;
  localparam logic [7:0] OP_BRANCH_NONZERO              = 8'h06;
  localparam logic [7:0] OP_BRANCH_CARRY_CLEAR          = 8'h07;
  localparam logic [7:0] OP_BRANCH_OVERFLOW             = 8'h08;
  localparam logic [7:0] OP_BRANCH_SIGNED_LESS          = 8'h09;
  localparam logic [7:0] OP_BRANCH_SIGNED_LESS_EQUAL    = 8'h0a;
  localparam logic [7:0] OP_BRANCH_UNSIGNED_HIGHER_SAME = 8'h0b;
  localparam logic [7:0] OP_BRANCH_NO_OVERFLOW          = 8'h0c;
  localparam logic [7:0] OP_BRANCH_SIGNED_GREATER_EQUAL = 8'h0d;
  localparam logic [7:0] OP_BRANCH_SIGNED_GREATER       = 8'h0e;
  localparam logic [7:0] OP_BRANCH_UNSIGNED_LOWER       = 8'h0f;
  localparam logic [7:0] OP_STATUS_IMMEDIATE_LOAD       = 8'hf0;
  localparam logic [7:0] OP_STACK_POINTER_LOAD          = 8'hfd;

  // ****************************************************************
  // Status register fields and reset values
  // ****************************************************************
  localparam int FLAG_CARRY    = 7;
  localparam int FLAG_NEGATIVE = 6;
  localparam int FLAG_ZERO     = 5;
  localparam int FLAG_OVERFLOW = 4;
  localparam int FLAG_IE_TWO   = 3;
  localparam int FLAG_IE_ONE   = 2;

  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  SP_RESET     = 8'h00;
  localparam logic [15:0] PC_RESET     = 16'h0000;

  // ****************************************************************
  // Cycle counts per path
  // ****************************************************************
  localparam logic [CNT_W-1:0] CYC_JUMP_NOT_TAKEN = 3'h5;
  localparam logic [CNT_W-1:0] CYC_JUMP_TAKEN     = 3'h7;
  localparam logic [CNT_W-1:0] CYC_SP_LOAD        = 3'h7;
  localparam logic [CNT_W-1:0] CYC_STATUS_LOAD    = 3'h6;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [7:0]        opcode;
    logic [7:0]        operand;
    logic [ADDR_W-1:0] nextAddr;
  } cbs_req_t;

  typedef enum logic [1:0] {
    KIND_JUMP   = 2'b00,
    KIND_SP     = 2'b01,
    KIND_STATUS = 2'b10,
    KIND_NONE   = 2'b11
  } cbs_kind_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } cbs_state_t;

endpackage

/* design/cbs_cond_eval.sv */
`timescale 1ns/100ps
module cbs_cond_eval
  import cbs_pkg::*;
(
  // Decode inputs
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] status,
  // Result
  output logic            isJump,
  output logic            condTrue
);

  logic c;
  logic n;
  logic z;
  logic v;

  assign c = status[FLAG_CARRY];
  assign n = status[FLAG_NEGATIVE];
  assign z = status[FLAG_ZERO];
  assign v = status[FLAG_OVERFLOW];

  always_comb begin
    isJump   = 1'b1;
    condTrue = 1'b0;
    case (opcode)
      OP_BRANCH_CARRY_SET:            condTrue = c;
      OP_BRANCH_CARRY_CLEAR:          condTrue = !c;
      OP_BRANCH_ZERO:                 condTrue = z;
      OP_BRANCH_NONZERO:              condTrue = !z;
      OP_BRANCH_UNSIGNED_LOWER:       condTrue = !c;
      OP_BRANCH_UNSIGNED_HIGHER_SAME: condTrue = c;
      OP_BRANCH_SIGNED_GREATER:       condTrue = !(z | (n ^ v));
      OP_BRANCH_SIGNED_LESS_EQUAL:    condTrue = z | (n ^ v);
      OP_BRANCH_SIGNED_GREATER_EQUAL: condTrue = !(n ^ v);
      OP_BRANCH_SIGNED_LESS:          condTrue = n ^ v;
      OP_BRANCH_NEGATIVE:             condTrue = n;
      OP_BRANCH_POSITIVE:             condTrue = !n && !z;
      OP_BRANCH_POSITIVE_OR_ZERO:     condTrue = !n;
      OP_BRANCH_NO_OVERFLOW:          condTrue = !v;
      OP_BRANCH_OVERFLOW:             condTrue = v;
      default:                        isJump   = 1'b0;
    endcase
  end

endmodule

/* design/cbs_cycle_counter.sv */
`timescale 1ns/100ps
module cbs_cycle_counter #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] loadValue,
  // Status
  output logic              lastCycle
);

  logic [W-1:0] remain_r;

  // The count is loaded with the total less one, since the taking edge is the first cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remain_r <= '0;
    end else if (load) begin
      remain_r <= W'(loadValue - W'(1));
    end else if (remain_r != '0) begin
      remain_r <= W'(remain_r - W'(1));
    end
  end

  assign lastCycle = (remain_r == W'(1));

endmodule

/* design/cbs_cond_branch_status_load.sv */
// Notes on behaviour
// - Taken jump loads next address plus offset; else continues at next address.
// - The offset byte is sign-extended before the add.
// - Jumps are two bytes and take 5 cycles when not taken.
// - A taken jump takes 7 cycles.
// - 03 branches on carry set, 07 on carry clear.
// - 02 branches on zero set, 06 on zero clear.
// - 0F branches on carry clear, 0B on carry set.
// - 0E branches when Z or (N xor V) is 0, 0A when 1.
// - 0D branches when N xor V is 0, 09 when 1.
// - 01 on negative, 04 on N and Z clear, 05 on N clear.
// - 0C branches on overflow clear, 08 on overflow set.
// - FD copies second accumulator to stack pointer in 7 cycles, flags untouched.
// - F0 writes its immediate byte to status in 6 cycles.
// - Status load sets every flag and both enables straight from the byte.
// - Interrupt enable and disable are just status loads with chosen values.
`timescale 1ns/100ps
module cbs_cond_branch_status_load
  import cbs_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Instruction request
  input  wire logic                      start,
  input  wire cbs_pkg::cbs_req_t         req,
  // Second accumulator and flag updates from other instructions
  input  wire logic [cbs_pkg::BYTE_W-1:0] accB,
  input  wire logic                      flagWrite,
  input  wire logic [cbs_pkg::BYTE_W-1:0] flagValue,
  // Architectural state
  output logic [cbs_pkg::ADDR_W-1:0]     pcR,
  output logic [cbs_pkg::BYTE_W-1:0]     spR,
  output logic [cbs_pkg::BYTE_W-1:0]     statusR,
  // Progress
  output logic                           busyR,
  output logic                           doneR,
  output logic                           takenR
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  cbs_state_t         state_r;
  cbs_state_t         state_nxt;
  cbs_kind_t          kind_r;
  cbs_kind_t          reqKind;
  logic               isJump;
  logic               condTrue;
  logic               take;
  logic               lastCycle;
  logic [ADDR_W-1:0]  target;
  logic [ADDR_W-1:0]  pcHold_r;
  logic [BYTE_W-1:0]  dataHold_r;
  logic               cond_r;
  logic [CNT_W-1:0]   cycles;

  cbs_cond_eval u_cond (
    .opcode   (req.opcode),
    .status   (statusR),
    .isJump   (isJump),
    .condTrue (condTrue)
  );

  always_comb begin
    if (isJump) begin
      reqKind = KIND_JUMP;
    end else if (req.opcode == OP_STACK_POINTER_LOAD) begin
      reqKind = KIND_SP;
    end else if (req.opcode == OP_STATUS_IMMEDIATE_LOAD) begin
      reqKind = KIND_STATUS;
    end else begin
      reqKind = KIND_NONE;
    end
  end

  // Unknown opcodes belong to other units, so they are simply not taken here.
  assign take = start && (state_r == ST_IDLE) && (reqKind != KIND_NONE);

  assign target = req.nextAddr + {{(ADDR_W-BYTE_W){req.operand[7]}}, req.operand};

  always_comb begin
    case (reqKind)
      KIND_JUMP:   cycles = condTrue ? CYC_JUMP_TAKEN : CYC_JUMP_NOT_TAKEN;
      KIND_SP:     cycles = CYC_SP_LOAD;
      KIND_STATUS: cycles = CYC_STATUS_LOAD;
      default:     cycles = CYC_JUMP_NOT_TAKEN;
    endcase
  end

  cbs_cycle_counter #(.W(CNT_W)) u_count (
    .clk       (clk),
    .rst       (rst),
    .load      (take),
    .loadValue (cycles),
    .lastCycle (lastCycle)
  );

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = take ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = lastCycle ? ST_IDLE : ST_EXEC;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyR <= 1'b0;
      doneR <= 1'b0;
    end else begin
      busyR <= (state_nxt == ST_EXEC);
      doneR <= (state_r == ST_EXEC) && lastCycle;
    end
  end

  // The condition is frozen at the taking edge so later flag traffic cannot change the path.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kind_r     <= KIND_NONE;
      cond_r     <= 1'b0;
      pcHold_r   <= PC_RESET;
      dataHold_r <= '0;
    end else if (take) begin
      kind_r     <= reqKind;
      cond_r     <= condTrue;
      pcHold_r   <= condTrue ? target : req.nextAddr;
      dataHold_r <= (reqKind == KIND_SP) ? accB : req.operand;
    end
  end

  // ****************************************************************
  // Architectural updates
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcR    <= PC_RESET;
      takenR <= 1'b0;
    end else if ((state_r == ST_EXEC) && lastCycle) begin
      if (kind_r == KIND_JUMP) begin
        pcR    <= pcHold_r;
        takenR <= cond_r;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spR <= SP_RESET;
    end else if ((state_r == ST_EXEC) && lastCycle && (kind_r == KIND_SP)) begin
      spR <= dataHold_r;
    end
  end

  // Outside flag writes are ignored while any instruction here is being taken or is executing.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusR <= STATUS_RESET;
    end else if ((state_r == ST_EXEC) && lastCycle && (kind_r == KIND_STATUS)) begin
      statusR <= dataHold_r;
    end else if (flagWrite && (state_r == ST_IDLE) && !take) begin
      statusR <= flagValue;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_taken_cycles;
    @(posedge clk) disable iff (rst)
    (take && isJump && condTrue) |-> ##1 (busyR && !doneR)[*6] ##1 doneR;
  endproperty
  a_taken_cycles: assert property (p_taken_cycles) else $error("taken jump not done in 7 cycles");

  property p_not_taken_cycles;
    @(posedge clk) disable iff (rst)
    (take && isJump && !condTrue) |-> ##1 (busyR && !doneR)[*4] ##1 doneR;
  endproperty
  a_not_taken_cycles: assert property (p_not_taken_cycles) else $error("fall-through not done in 5 cycles");

  property p_taken_pc;
    @(posedge clk) disable iff (rst)
    (take && isJump && condTrue) |-> ##7 (pcR == $past(target, 7)) && takenR;
  endproperty
  a_taken_pc: assert property (p_taken_pc) else $error("taken jump target wrong");

  property p_not_taken_pc;
    @(posedge clk) disable iff (rst)
    (take && isJump && !condTrue) |-> ##5 (pcR == $past(req.nextAddr, 5)) && !takenR;
  endproperty
  a_not_taken_pc: assert property (p_not_taken_pc) else $error("fall-through address wrong");

  property p_sp_load;
    @(posedge clk) disable iff (rst)
    (take && (reqKind == KIND_SP)) |-> ##7 doneR && (spR == $past(accB, 7));
  endproperty
  a_sp_load: assert property (p_sp_load) else $error("stack pointer load wrong");

  property p_sp_flags;
    @(posedge clk) disable iff (rst)
    (take && (reqKind == KIND_SP)) |-> ##7 (statusR == $past(statusR, 7));
  endproperty
  a_sp_flags: assert property (p_sp_flags) else $error("stack pointer load changed flags");

  property p_status_load;
    @(posedge clk) disable iff (rst)
    (take && (reqKind == KIND_STATUS)) |-> ##6 doneR && (statusR == $past(req.operand, 6));
  endproperty
  a_status_load: assert property (p_status_load) else $error("status load wrong");

  property p_jump_flags;
    @(posedge clk) disable iff (rst)
    (take && isJump) |-> ##5 (statusR == $past(statusR, 5));
  endproperty
  a_jump_flags: assert property (p_jump_flags) else $error("jump changed flags");

  property p_done_pulse;
    @(posedge clk) disable iff (rst)
    doneR |=> !doneR;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  // pc, taken flag and sp may only move on the done edge of their own kind; status is checked only when the prior cycle was busy.
  property p_pc_source;
    @(posedge clk) disable iff (rst)
    !$stable(pcR) |-> doneR && (kind_r == KIND_JUMP);
  endproperty
  a_pc_source: assert property (p_pc_source) else $error("pc moved outside a jump");

  property p_taken_source;
    @(posedge clk) disable iff (rst)
    !$stable(takenR) |-> doneR && (kind_r == KIND_JUMP);
  endproperty
  a_taken_source: assert property (p_taken_source) else $error("taken flag moved outside a jump");

  property p_sp_source;
    @(posedge clk) disable iff (rst)
    !$stable(spR) |-> doneR && (kind_r == KIND_SP);
  endproperty
  a_sp_source: assert property (p_sp_source) else $error("stack pointer moved outside its load");

  property p_status_source;
    @(posedge clk) disable iff (rst)
    ($past(busyR) && !$stable(statusR)) |-> doneR && (kind_r == KIND_STATUS);
  endproperty
  a_status_source: assert property (p_status_source) else $error("status moved during a non-status op");

  property p_done_busy;
    @(posedge clk) disable iff (rst)
    doneR |-> !busyR;
  endproperty
  a_done_busy: assert property (p_done_busy) else $error("busy still high in done cycle");

  property p_refused;
    @(posedge clk) disable iff (rst)
    (start && !busyR && (reqKind == KIND_NONE)) |=> !busyR;
  endproperty
  a_refused: assert property (p_refused) else $error("foreign opcode was taken");

  property p_flag_write;
    @(posedge clk) disable iff (rst)
    (flagWrite && !busyR && !take) |=> (statusR == $past(flagValue));
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("idle flag write lost");

  property p_flag_held;
    @(posedge clk) disable iff (rst)
    (flagWrite && (busyR || take) && !(busyR && lastCycle && (kind_r == KIND_STATUS))) |=> $stable(statusR);
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("flag write landed while busy");

  property p_sp_pc;
    @(posedge clk) disable iff (rst)
    (take && (reqKind == KIND_SP)) |-> ##7 (pcR == $past(pcR, 7));
  endproperty
  a_sp_pc: assert property (p_sp_pc) else $error("stack pointer load moved pc");

  property p_status_pc;
    @(posedge clk) disable iff (rst)
    (take && (reqKind == KIND_STATUS)) |-> ##6 (pcR == $past(pcR, 6));
  endproperty
  a_status_pc: assert property (p_status_pc) else $error("status load moved pc");

  property p_jump_sp;
    @(posedge clk) disable iff (rst)
    (take && isJump) |-> ##5 (spR == $past(spR, 5));
  endproperty
  a_jump_sp: assert property (p_jump_sp) else $error("jump changed stack pointer");

  c_taken: cover property (@(posedge clk) disable iff (rst) take && isJump && condTrue);
  c_not_taken: cover property (@(posedge clk) disable iff (rst) take && isJump && !condTrue);
  c_sp: cover property (@(posedge clk) disable iff (rst) doneR && (kind_r == KIND_SP));
  c_status: cover property (@(posedge clk) disable iff (rst) doneR && (kind_r == KIND_STATUS));

endmodule

/* test/cbs_prog_mem.sv */
`timescale 1ns/100ps
module cbs_prog_mem
  import cbs_pkg::*;
(
  // Clock
  input  wire logic                       clk,
  // Loading port
  input  wire logic                       wrEn,
  input  wire logic [cbs_pkg::ADDR_W-1:0] wrAddr,
  input  wire logic [cbs_pkg::BYTE_W-1:0] wrOp,
  input  wire logic [cbs_pkg::BYTE_W-1:0] wrOpd,
  // Fetch port
  input  wire logic [cbs_pkg::ADDR_W-1:0] fetchAddr,
  output cbs_pkg::cbs_req_t               fetchReq
);
  import cbs_pkg::*;
  // Only the low address byte is kept, so the bench must load a slot before it fetches it.
  logic [7:0] memR [0:255];
  logic [7:0] lenW;

  always_ff @(posedge clk) begin
    if (wrEn) begin
      memR[wrAddr[7:0]] <= wrOp;
      memR[wrAddr[7:0] + 8'h01] <= wrOpd;
    end
  end

  assign lenW = (memR[fetchAddr[7:0]] == OP_STACK_POINTER_LOAD) ? 8'h01 : 8'h02;
  assign fetchReq = {memR[fetchAddr[7:0]], memR[fetchAddr[7:0] + 8'h01], fetchAddr + {8'h00, lenW}};
endmodule

/* test/cbs_cond_branch_status_load_test.sv */
`timescale 1ns/100ps
module cbs_cond_branch_status_load_test;
  import cbs_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              start = 1'b0;
  logic              flagWrite = 1'b0;
  logic [7:0]        flagValue = 8'h00;
  logic [7:0]        accB = 8'h00;
  logic              pmWrEn = 1'b0;
  logic [15:0]       pmWrAddr = 16'h0000;
  logic [7:0]        pmWrOp = 8'h00;
  logic [7:0]        pmWrOpd = 8'h00;
  logic [15:0]       fetchAddr = 16'h0000;
  cbs_req_t          req;
  logic [15:0]       pcR;
  logic [7:0]        spR;
  logic [7:0]        statusR;
  logic              busyR;
  logic              doneR;
  logic              takenR;
  int                fails = 0;
  int                comparisons = 0;
  int                cycles = 0;
  int                n;
  logic [7:0]        st;
  logic [7:0]        opd;
  logic [15:0]       addr;
  logic [15:0]       tgt;
  logic [15:0]       pcOld;
  logic              tk;
  logic              bsy;
  logic [7:0]        stVals [6] = '{8'h0c, 8'h04, 8'h08, 8'h00, 8'hf3, 8'ha5};

  always #20 clk = ~clk;

  cbs_cond_branch_status_load cbs_cond_branch_status_load_i (.clk(clk), .rst(rst), .start(start), .req(req),
    .accB(accB), .flagWrite(flagWrite), .flagValue(flagValue), .pcR(pcR), .spR(spR), .statusR(statusR),
    .busyR(busyR), .doneR(doneR), .takenR(takenR));
  cbs_prog_mem cbs_prog_mem_i (.clk(clk), .wrEn(pmWrEn), .wrAddr(pmWrAddr), .wrOp(pmWrOp), .wrOpd(pmWrOpd),
    .fetchAddr(fetchAddr), .fetchReq(req));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic test_done;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic setStatus(input logic [7:0] v);
    flagWrite = 1'b1;
    flagValue = v;
    tick();
    flagWrite = 1'b0;
  endtask

  // Accumulator and flag input are disturbed while busy, so late sampling shows up.
  task automatic exec(input logic [7:0] op, input logic [7:0] o8, input logic [15:0] a, output int cnt);
    pmWrEn = 1'b1;
    pmWrAddr = a;
    pmWrOp = op;
    pmWrOpd = o8;
    fetchAddr = a;
    tick();
    pmWrEn = 1'b0;
    start = 1'b1;
    tick();
    start = 1'b0;
    bsy = busyR;
    accB = ~accB;
    flagWrite = 1'b1;
    flagValue = ~flagValue;
    tick();
    flagWrite = 1'b0;
    cnt = 2;
    while (doneR !== 1'b1 && cnt < 12) begin
      tick();
      cnt++;
    end
  endtask

  function automatic logic expTake(input logic [7:0] op, input logic [7:0] s);
    logic c, ng, z, v;
    c = s[FLAG_CARRY];
    ng = s[FLAG_NEGATIVE];
    z = s[FLAG_ZERO];
    v = s[FLAG_OVERFLOW];
    case (op)
      8'h01: return ng;
      8'h02: return z;
      8'h03: return c;
      8'h04: return !ng && !z;
      8'h05: return !ng;
      8'h06: return !z;
      8'h07: return !c;
      8'h08: return v;
      8'h09: return ng ^ v;
      8'h0a: return z | (ng ^ v);
      8'h0b: return c;
      8'h0c: return !v;
      8'h0d: return !(ng ^ v);
      8'h0e: return !(z | (ng ^ v));
      default: return !c;
    endcase
  endfunction

  // ****************************************************************
  // Timeout
  // ****************************************************************
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fails++;
      test_done();
    end
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    check("reset pc", pcR, 16'h0000);
    check("reset state", {spR, statusR}, 16'h0000);
    // Every condition code against every flag pattern, ending on a wrapping address.
    for (int o = 1; o < 16; o++) begin
      for (int f = 0; f < 16; f++) begin
        st = {f[3:0], o[3:0]};
        opd = {f[0], f[3:1], o[3:0]};
        addr = {o[3:0], f[3:0], 8'hfe};
        tk = expTake(o[7:0], st);
        tgt = tk ? addr + 16'h0002 + {{8{opd[7]}}, opd} : addr + 16'h0002;
        setStatus(st);
        exec(o[7:0], opd, addr, n);
        check("jump pc", pcR, tgt);
        check("jump taken", {15'h0000, takenR}, {15'h0000, tk});
        check("jump cycles", n[15:0], tk ? 16'h0007 : 16'h0005);
        check("jump status", {8'h00, statusR}, {8'h00, st});
        check("jump busy", {15'h0000, bsy}, 16'h0001);
      end
    end
    // Status loads, including the interrupt enable and disable patterns.
    foreach (stVals[i]) begin
      pcOld = pcR;
      exec(OP_STATUS_IMMEDIATE_LOAD, stVals[i], 16'h2000 + 16'(i), n);
      check("status load", {8'h00, statusR}, {8'h00, stVals[i]});
      check("status cycles", n[15:0], 16'h0006);
      check("status pc", pcR, pcOld);
    end
    setStatus(8'h96);
    accB = 8'h5a;
    exec(OP_STACK_POINTER_LOAD, 8'h00, 16'h3000, n);
    check("sp load", {8'h00, spR}, 16'h005a);
    check("sp cycles", n[15:0], 16'h0007);
    check("sp status", {8'h00, statusR}, 16'h0096);
    check("sp busy", {15'h0000, bsy}, 16'h0001);
    // An undefined opcode must never complete.
    pcOld = pcR;
    exec(8'h00, 8'h10, 16'h4000, n);
    check("refused", n[15:0], 16'h000c);
    check("refused pc", pcR, pcOld);
    check("refused busy", {15'h0000, bsy}, 16'h0000);
    test_done();
  end
endmodule
